// [arsf_core_model.sv]
// conversion core and sequencer model that starts conversions and reports their ends
`timescale 1ns/1ns
`default_nettype none
module arsf_core_model
  import arsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [CH_W-1:0] go_chan,
  input wire logic [RES_W-1:0] go_data,
  input wire logic [3:0] lat,
  output logic conv_start,
  output logic [CH_W-1:0] conv_chan,
  output arsf_eoc_t eoc_in,
  output logic last_cyc
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  logic [RES_W-1:0] data_reg;
  // the end pulse goes out on the edge after the count runs out
  assign last_cyc = busy_reg && cnt_reg == 4'h0;
  // one conversion at a time; idle result lines keep toggling
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      data_reg <= 10'h000;
      conv_start <= 1'b0;
      conv_chan <= 3'h0;
      eoc_in <= '0;
    end
    else
    begin
      conv_start <= go && !busy_reg;
      eoc_in.valid <= last_cyc;
      eoc_in.data <= last_cyc ? data_reg : ~eoc_in.data;
      eoc_in.chan <= last_cyc ? conv_chan : eoc_in.chan + 3'h1;
      if (go && !busy_reg)
      begin
        busy_reg <= 1'b1;
        cnt_reg <= lat;
        conv_chan <= go_chan;
        data_reg <= go_data;
      end
      else if (busy_reg)
      begin
        cnt_reg <= cnt_reg - 4'h1;
        busy_reg <= !last_cyc;
      end
    end
  end
endmodule // arsf_core_model
`default_nettype wire

// [arsf_flag_cell.sv]
// sticky status flag where a set in the same cycle beats a clear
`timescale 1ns/1ns
`default_nettype none
module arsf_flag_cell
  import arsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  logic q_reg;
  logic q_next;

  // set dominates clear so a coincident event is never lost
  always_comb
  begin
    q_next = q_reg;
    if (clr)
      q_next = 1'b0;
    if (set)
      q_next = 1'b1;
  end

  // register the flag
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q_reg <= RST_FLAG;
    else
      q_reg <= q_next;
  end

  assign q = q_reg;
endmodule // arsf_flag_cell
`default_nettype wire

// [arsf_pkg.sv]
// shared constants and carrier types for the converter result and status flag block
package arsf_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int RES_W = 10;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [RES_W-1:0] RST_RESULT = 10'h000;
  localparam logic [CH_W-1:0] RST_CHAN = 3'h0;
  localparam logic [NUM_CH-1:0] RST_ENABLE = 8'h00;
  localparam logic [NUM_CH-1:0] RST_DROP = 8'h00;

  // end-of-conversion event from the conversion core
  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] chan;
    logic [RES_W-1:0] data;
  } arsf_eoc_t;

  // software read strobes
  typedef struct packed {
    logic last_rd;
    logic chan_rd;
    logic [CH_W-1:0] chan_sel;
    logic status_rd;
  } arsf_read_t;

  // status word seen by software
  typedef struct packed {
    logic result_ready_flag;
    logic global_overrun_flag;
    logic [NUM_CH-1:0] channel_overrun_flag;
    logic [NUM_CH-1:0] eoc_flag;
  } arsf_status_t;

  // sleep sequencing states
  typedef enum logic [2:0] {
    SLP_AWAKE = 3'b001,
    SLP_ARMED = 3'b010,
    SLP_ASLEEP = 3'b100
  } arsf_sleep_t;
endpackage

// [arsf_result_mem.sv]
// per-channel result storage with registered read data
`timescale 1ns/1ns
`default_nettype none
module arsf_result_mem
  import arsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [CH_W-1:0] wr_chan,
  input wire logic [RES_W-1:0] wr_data,
  input wire logic [CH_W-1:0] rd_chan,
  output logic [RES_W-1:0] rd_data
);
  logic [RES_W-1:0] mem_reg [NUM_CH];
  logic [RES_W-1:0] rd_data_reg;

  // storage array and read register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
        mem_reg[i] <= RST_RESULT;
      rd_data_reg <= RST_RESULT;
    end
    else
    begin
      if (wr_en)
        mem_reg[wr_chan] <= wr_data;
      rd_data_reg <= mem_reg[rd_chan];
    end
  end

  assign rd_data = rd_data_reg;
endmodule // arsf_result_mem
`default_nettype wire

// [arsf_result_status.sv]
// result registers, status flags and sleep sequencing of the converter controller
//
// Notes on behaviour
// - the result-ready flag clears only on a read of the last-result register, never on a channel read.
// - an end of conversion on a disabled channel stores nothing and does not raise result-ready.
// - a channel read in the cycle another enabled channel ends still lets result-ready rise.
// - disabling one channel as another ends still stores the ending channel's result and raises result-ready.
// - a status read at an end of conversion still clears or sets the global overrun flag correctly.
// - a stored end of conversion while result-ready is set raises the global overrun flag.
// - a channel read coinciding with another channel's overrunning end still raises global overrun.
// - disabling a channel as another overruns raises that channel's overrun flag, and the global one when result-ready is set.
// - a status read clears a channel overrun flag whose end flag is clear, even as that channel ends.
// - a channel's end flag clears on a read of its own result or of the last result it supplied.
// - a channel disabled during its conversion, after its start cycle, never raises its end flag.
// - a channel read clears only that channel's end flag, whatever else ends in the cycle.
// - sleep selected while idle takes effect only after the next conversion completes.
`timescale 1ns/1ns
`default_nettype none
module arsf_result_status
  import arsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire arsf_eoc_t eoc_in,
  input wire logic conv_start,
  input wire logic [CH_W-1:0] conv_chan,
  input wire logic [NUM_CH-1:0] chan_enable,
  input wire arsf_read_t rd_in,
  input wire logic sleep_sel,
  output arsf_status_t status,
  output logic [RES_W-1:0] last_converted_result,
  output logic [CH_W-1:0] last_chan,
  output logic [RES_W-1:0] channel_result_register,
  output logic sleep_active
);
  // ----------------------------------------------------------------
  // conversion acceptance
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] enable_reg;
  logic [NUM_CH-1:0] enable_next;
  logic [NUM_CH-1:0] drop_reg;
  logic [NUM_CH-1:0] drop_next;
  logic store;
  logic [NUM_CH-1:0] eoc_q;
  logic [NUM_CH-1:0] ovr_q;
  logic ready_q;
  logic govr_q;

  // a channel whose enable falls mid-conversion is dropped until restarted
  always_comb
  begin
    enable_next = chan_enable;
    drop_next = drop_reg | (enable_reg & ~chan_enable);
    if (conv_start)
      drop_next[conv_chan] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_reg <= RST_ENABLE;
      drop_reg <= RST_DROP;
    end
    else
    begin
      enable_reg <= enable_next;
      drop_reg <= drop_next;
    end
  end

  // store only for an enabled, undropped channel; other channels' reads or disables do not matter
  assign store = eoc_in.valid && chan_enable[eoc_in.chan]
    && !drop_reg[eoc_in.chan];

  // ----------------------------------------------------------------
  // last result register
  // ----------------------------------------------------------------
  logic [RES_W-1:0] last_res_reg;
  logic [RES_W-1:0] last_res_next;
  logic [CH_W-1:0] last_chan_reg;
  logic [CH_W-1:0] last_chan_next;

  always_comb
  begin
    last_res_next = last_res_reg;
    last_chan_next = last_chan_reg;
    if (store)
    begin
      last_res_next = eoc_in.data;
      last_chan_next = eoc_in.chan;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_res_reg <= RST_RESULT;
      last_chan_reg <= RST_CHAN;
    end
    else
    begin
      last_res_reg <= last_res_next;
      last_chan_reg <= last_chan_next;
    end
  end

  assign last_converted_result = last_res_reg;
  assign last_chan = last_chan_reg;

  // per-channel result storage, read data one cycle after the select
  arsf_result_mem u_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(store),
    .wr_chan(eoc_in.chan),
    .wr_data(eoc_in.data),
    .rd_chan(rd_in.chan_sel),
    .rd_data(channel_result_register)
  );

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] eoc_set;
  logic [NUM_CH-1:0] eoc_clr;
  logic [NUM_CH-1:0] ovr_set;
  logic [NUM_CH-1:0] ovr_clr;
  logic ready_set;
  logic ready_clr;
  logic govr_set;
  logic govr_clr;

  // flag set and clear terms, all computed from values before the edge
  always_comb
  begin
    eoc_set = '0;
    eoc_clr = '0;
    ovr_set = '0;
    if (store)
    begin
      eoc_set[eoc_in.chan] = 1'b1;
      ovr_set[eoc_in.chan] = eoc_q[eoc_in.chan];
    end
    if (rd_in.chan_rd)
      eoc_clr[rd_in.chan_sel] = 1'b1;
    if (rd_in.last_rd)
      eoc_clr[last_chan_reg] = 1'b1;
    ovr_clr = {NUM_CH{rd_in.status_rd}};
    ready_set = store;
    ready_clr = rd_in.last_rd;
    govr_set = store && ready_q;
    govr_clr = rd_in.status_rd;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_chan
      arsf_flag_cell u_eoc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .set(eoc_set[g]),
        .clr(eoc_clr[g]),
        .q(eoc_q[g])
      );
      arsf_flag_cell u_ovr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .set(ovr_set[g]),
        .clr(ovr_clr[g]),
        .q(ovr_q[g])
      );
    end
  endgenerate

  arsf_flag_cell u_ready (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set(ready_set),
    .clr(ready_clr),
    .q(ready_q)
  );

  arsf_flag_cell u_govr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set(govr_set),
    .clr(govr_clr),
    .q(govr_q)
  );

  // status word out
  always_comb
  begin
    status.result_ready_flag = ready_q;
    status.global_overrun_flag = govr_q;
    status.channel_overrun_flag = ovr_q;
    status.eoc_flag = eoc_q;
  end

  // ----------------------------------------------------------------
  // sleep sequencing
  // ----------------------------------------------------------------
  arsf_sleep_t slp_reg;
  arsf_sleep_t slp_next;

  // sleep arms on selection and takes effect at the next end of conversion, whether stored or not
  always_comb
  begin
    slp_next = slp_reg;
    unique case (slp_reg)
      SLP_AWAKE:
        if (sleep_sel)
          slp_next = SLP_ARMED;
      SLP_ARMED:
        if (!sleep_sel)
          slp_next = SLP_AWAKE;
        else if (eoc_in.valid)
          slp_next = SLP_ASLEEP;
      SLP_ASLEEP:
        if (!sleep_sel || conv_start)
          slp_next = SLP_AWAKE;
      default:
        slp_next = SLP_AWAKE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      slp_reg <= SLP_AWAKE;
    else
      slp_reg <= slp_next;
  end

  assign sleep_active = (slp_reg == SLP_ASLEEP);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_ready_chan_read: assert property (
    ready_q && rd_in.chan_rd && !rd_in.last_rd |=> ready_q)
    else $error("result ready cleared by a channel read");
  a_ready_last_read: assert property (
    rd_in.last_rd && !store |=> !ready_q)
    else $error("result ready not cleared by last read");
  a_ready_on_store: assert property (
    store |=> ready_q && last_res_reg == $past(eoc_in.data))
    else $error("stored result did not raise result ready");
  a_disabled_no_store: assert property (
    eoc_in.valid && !chan_enable[eoc_in.chan] && !ready_q |=> !ready_q || $past(store))
    else $error("disabled channel raised result ready");
  a_govr_set: assert property (
    store && ready_q |=> govr_q)
    else $error("overrun on ready not flagged");
  a_govr_status_clr: assert property (
    rd_in.status_rd && !(store && ready_q) |=> !govr_q)
    else $error("status read did not clear global overrun");
  a_chan_ovr_set: assert property (
    store && eoc_q[eoc_in.chan] |=> ovr_q[$past(eoc_in.chan)] && govr_q || !$past(ready_q))
    else $error("channel overrun not flagged");
  a_ovr_status_clr: assert property (
    rd_in.status_rd && !store |=> ovr_q == '0)
    else $error("status read left a channel overrun set");
  a_eoc_only_sel: assert property (
    rd_in.chan_rd && !rd_in.last_rd && !store |=> (eoc_q | (NUM_CH'(1) << $past(rd_in.chan_sel)))
      == ($past(eoc_q) | (NUM_CH'(1) << $past(rd_in.chan_sel))))
    else $error("channel read cleared another end flag");
  a_dropped_no_eoc: assert property (
    eoc_in.valid && drop_reg[eoc_in.chan] && !eoc_q[eoc_in.chan] |=> !eoc_q[$past(eoc_in.chan)])
    else $error("dropped channel raised its end flag");
  a_sleep_after_conv: assert property (
    slp_reg == SLP_ARMED && sleep_sel && !eoc_in.valid |=> !sleep_active)
    else $error("sleep entered before a conversion ended");
  a_disabled_last_rd: assert property (
    rd_in.last_rd && eoc_in.valid && !chan_enable[eoc_in.chan] |=> !ready_q)
    else $error("disabled channel end kept result ready");
  a_store_with_disable: assert property (
    store && chan_enable != '1 |=> ready_q && eoc_q[$past(eoc_in.chan)])
    else $error("store beside a disable lost result ready");
  a_last_rd_eoc: assert property (
    rd_in.last_rd && !(store && eoc_in.chan == last_chan_reg) |=> !eoc_q[$past(last_chan_reg)])
    else $error("last result read left its end flag set");
  a_store_last_chan: assert property (
    store |=> last_chan_reg == $past(eoc_in.chan) && eoc_q[$past(eoc_in.chan)])
    else $error("stored end did not record its channel");
  a_sleep_on_end: assert property (
    slp_reg == SLP_ARMED && sleep_sel && eoc_in.valid |=> sleep_active)
    else $error("armed sleep not entered at end of conversion");

  // main scenarios worth seeing at least once
  c_overrun: cover property (store && ready_q && rd_in.status_rd);
  c_disabled_end: cover property (eoc_in.valid && !store && rd_in.last_rd);
  c_chan_read_store: cover property (store && rd_in.chan_rd && rd_in.chan_sel != eoc_in.chan);
  c_sleep: cover property (slp_reg == SLP_ARMED ##1 sleep_active);
endmodule // arsf_result_status
`default_nettype wire

// [arsf_result_status_test.sv]
// self-checking bench for the result and status flag block
`timescale 1ns/1ns
`default_nettype none
module arsf_result_status_test
  import arsf_pkg::*;
;
  typedef struct packed {
    arsf_status_t st;
    logic [RES_W-1:0] last;
    logic [CH_W-1:0] lch;
    logic [RES_W-1:0] crr;
    logic slp;
  } arsf_exp_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [CH_W-1:0] go_chan = 3'h0;
  logic [RES_W-1:0] go_data = 10'h000;
  logic [3:0] lat = 4'h2;
  logic [NUM_CH-1:0] chan_enable = 8'hFF;
  arsf_read_t rd_in = '0;
  logic sleep_sel = 1'b0;
  logic conv_start, last_cyc, sleep_active, arm;
  logic [CH_W-1:0] conv_chan, last_chan;
  arsf_eoc_t eoc_in;
  arsf_status_t status;
  logic [RES_W-1:0] last_converted_result, channel_result_register;
  logic [RES_W-1:0] mem [NUM_CH];
  logic [NUM_CH-1:0] en_prev, drop;
  arsf_exp_t m;
  arsf_exp_t exp_q[$];
  int num_errors = 0;
  int n_checks = 0;
  int seed = 76;
  always #20 ref_clk = ~ref_clk;
  arsf_result_status arsf_result_status_i (.ref_clk(ref_clk), .rst_n(rst_n), .eoc_in(eoc_in),
    .conv_start(conv_start), .conv_chan(conv_chan), .chan_enable(chan_enable), .rd_in(rd_in),
    .sleep_sel(sleep_sel), .status(status), .last_converted_result(last_converted_result),
    .last_chan(last_chan), .channel_result_register(channel_result_register),
    .sleep_active(sleep_active));
  arsf_core_model arsf_core_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .go(go),
    .go_chan(go_chan), .go_data(go_data), .lat(lat), .conv_start(conv_start),
    .conv_chan(conv_chan), .eoc_in(eoc_in), .last_cyc(last_cyc));
  // ----------------------------------------
  // reference model and output monitor
  // ----------------------------------------
  // notes the expected outputs for every sampled edge
  always @(posedge ref_clk or negedge rst_n)
  begin : refm
    logic st, ov;
    if (!rst_n)
    begin
      m = '0;
      foreach (mem[i]) mem[i] = 10'h000;
      en_prev = 8'h00;
      drop = 8'h00;
      arm = 1'b0;
    end
    else
    begin
      st = eoc_in.valid && chan_enable[eoc_in.chan] && !drop[eoc_in.chan];
      ov = st && m.st.eoc_flag[eoc_in.chan];
      m.crr = mem[rd_in.chan_sel];
      m.slp = sleep_sel && !conv_start && (m.slp || (arm && eoc_in.valid));
      arm = sleep_sel;
      m.st.global_overrun_flag = (st && m.st.result_ready_flag) ||
        (m.st.global_overrun_flag && !rd_in.status_rd);
      if (rd_in.status_rd) m.st.channel_overrun_flag = 8'h00;
      if (ov) m.st.channel_overrun_flag[eoc_in.chan] = 1'b1;
      if (rd_in.chan_rd) m.st.eoc_flag[rd_in.chan_sel] = 1'b0;
      if (rd_in.last_rd) m.st.eoc_flag[m.lch] = 1'b0;
      m.st.result_ready_flag = st || (m.st.result_ready_flag && !rd_in.last_rd);
      if (st)
      begin
        m.st.eoc_flag[eoc_in.chan] = 1'b1;
        m.last = eoc_in.data;
        m.lch = eoc_in.chan;
        mem[eoc_in.chan] = eoc_in.data;
      end
      drop = (drop | (en_prev & ~chan_enable)) & ~(conv_start ? 8'h01 << conv_chan : 8'h00);
      en_prev = chan_enable;
      exp_q.push_back(m);
    end
  end
  // compares the oldest note with what the block shows
  always @(negedge ref_clk)
    if (exp_q.size() > 0)
    begin : mon
      arsf_exp_t e;
      e = exp_q.pop_front();
      chk_f("ready", {7'h00, e.st.result_ready_flag}, {7'h00, status.result_ready_flag});
      chk_f("govr", {7'h00, e.st.global_overrun_flag}, {7'h00, status.global_overrun_flag});
      chk_f("covr", e.st.channel_overrun_flag, status.channel_overrun_flag);
      chk_f("eoc", e.st.eoc_flag, status.eoc_flag);
      chk_f("sleep", {7'h00, e.slp}, {7'h00, sleep_active});
      chk_f("lchan", {5'h00, e.lch}, {5'h00, last_chan});
      chk_r("last", e.last, last_converted_result);
      chk_r("chres", e.crr, channel_result_register);
    end
  task automatic chk_f(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_r(input string nm, input logic [RES_W-1:0] e, input logic [RES_W-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  function automatic arsf_read_t crd(input logic [CH_W-1:0] z);
    return {1'b0, 1'b1, z, 1'b0};
  endfunction
  // one read strobe for one cycle; an idle edge first so the strobe is not driven twice at once
  task automatic rd(input arsf_read_t rv);
    @(posedge ref_clk);
    rd_in <= rv;
    @(posedge ref_clk);
    rd_in <= '0;
  endtask
  // one conversion; enables me during it, read rv and enables fe at its end
  task automatic ev(input logic [CH_W-1:0] ch, input arsf_read_t rv,
    input logic [NUM_CH-1:0] me, input logic [NUM_CH-1:0] fe);
    int k;
    go <= 1'b1;
    go_chan <= ch;
    go_data <= 10'($random(seed));
    lat <= {2'h0, 2'($random(seed))} + 4'h2;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    chan_enable <= me;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (!last_cyc && k < 20);
    if (!last_cyc) num_errors++;
    rd_in <= rv;
    chan_enable <= fe;
    @(posedge ref_clk);
    rd_in <= '0;
    chan_enable <= 8'hFF;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog far beyond the expected run length
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    ev(3'h1, '0, 8'hFF, 8'hFF);
    rd(crd(3'h5));
    ev(3'h2, crd(3'h5), 8'hFF, 8'hFF);
    rd(6'h01);
    ev(3'h3, '0, 8'hFF, 8'hFF);
    ev(3'h4, '0, 8'hFF, 8'hFF);
    rd(6'h01);
    ev(3'h3, crd(3'h5), 8'hFF, 8'hFF);
    rd(6'h20);
    ev(3'h4, '0, 8'hFF, 8'hFF);
    ev(3'h6, 6'h20, 8'hFF, 8'hBF);
    ev(3'h2, '0, 8'hFF, 8'h7F);
    ev(3'h5, 6'h01, 8'hFF, 8'hFF);
    rd(6'h20);
    ev(3'h5, 6'h01, 8'hFF, 8'hFF);
    ev(3'h5, '0, 8'hFF, 8'hFE);
    rd(crd(3'h5));
    ev(3'h5, 6'h01, 8'hFF, 8'hFF);
    ev(3'h0, crd(3'h6), 8'hFE, 8'hFF);
    ev(3'h0, '0, 8'hFF, 8'hFF);
    sleep_sel <= 1'b1;
    repeat (5) @(posedge ref_clk);
    ev(3'h7, '0, 8'hFF, 8'hFF);
    repeat (3) @(posedge ref_clk);
    repeat (60)
    begin
      sleep_sel <= 1'($random(seed));
      ev(3'($random(seed)), arsf_read_t'($random(seed)), 8'hFF ^ (8'h01 << 3'($random(seed))),
        8'hFF ^ (8'h01 << 3'($random(seed))));
    end
    repeat (3) @(posedge ref_clk);
    end_sim();
  end
endmodule // arsf_result_status_test
`default_nettype wire
